// *** logic/ascs_sequencer.sv ***
// Sampling, conversion and multi-sample mode sequencer
module ascs_sequencer #(
	parameter int CHAN_BITS = 3,
	parameter int FIFO_DEPTH = 8
) (
	input wire logic I_CORE_CLK,
	input wire logic I_RST_B,
	input wire logic i_sclk_fall,
	input wire logic i_osc_tick,
	input wire logic i_frame_start,
	input wire logic i_conversion_strobe_b,
	input wire logic i_config_write_command,
	input wire logic [1:0] i_cfg_mode,
	input wire logic i_cfg_ext_clk,
	input wire logic i_cfg_long_sample,
	input wire logic [1:0] i_cfg_thresh,
	input wire logic [1:0] i_cfg_sweep,
	input wire logic i_select_command,
	input wire logic [CHAN_BITS-1:0] i_select_chan,
	input wire logic i_fifo_read_command,
	output logic o_sampling,
	output logic o_eoc_b,
	output logic o_int_b,
	output logic [CHAN_BITS-1:0] o_chan,
	output logic o_fifo_wr,
	output logic [2:0] o_fifo_level,
	output logic o_result_ready,
	output logic o_ext_mode
);
	initial begin
		if (CHAN_BITS < 2 || FIFO_DEPTH != 8) begin
			$error("ascs_sequencer: unsupported parameters");
		end
	end

	ascs_pkg::ascs_state_t state;
	logic [1:0] mode;
	logic ext_clk;
	logic long_sample;
	logic [1:0] thresh;
	logic [1:0] sweep;
	logic [5:0] sclk_cnt;
	logic [1:0] div4;
	logic [4:0] conv_cnt;
	logic [3:0] delay_cnt;
	logic strobe_q;
	logic ext_wait;
	logic [1:0] ext_frames;
	logic armed;
	logic [2:0] sweep_pos;
	logic [2:0] target;
	logic conv_tick;
	logic strobe_fall;
	logic strobe_rise;
	logic trigger_frame;
	logic last_sample;

	assign strobe_fall = strobe_q && !i_conversion_strobe_b;
	assign strobe_rise = !strobe_q && i_conversion_strobe_b;
	// Conversion clock source
	assign conv_tick = ext_clk ? (i_sclk_fall && div4 == 2'h3) : i_osc_tick;

	always_comb begin
		case (thresh)
			2'h0: target = ascs_pkg::LEVEL_T00;
			2'h1: target = ascs_pkg::LEVEL_T01;
			2'h2: target = ascs_pkg::LEVEL_T10;
			default: target = ascs_pkg::LEVEL_T11;
		endcase
	end

	assign last_sample = (mode == ascs_pkg::MODE_ONE_SHOT) || (o_fifo_level + 3'h1 == target) ||
		(o_fifo_level == target);
	// A frame in extended mode arms and counts toward leaving extended mode, it never starts sampling
	assign trigger_frame = i_frame_start && !o_ext_mode;

	// Configuration persists until the next config write
	always_ff @(posedge I_CORE_CLK or negedge I_RST_B) begin
		if (!I_RST_B) begin
			mode <= ascs_pkg::RST_MODE;
			ext_clk <= 1'b0;
			long_sample <= 1'b0;
			thresh <= ascs_pkg::RST_THRESH;
			sweep <= ascs_pkg::RST_SWEEP;
		end else if (i_config_write_command) begin
			mode <= i_cfg_mode;
			ext_clk <= i_cfg_ext_clk;
			long_sample <= i_cfg_long_sample;
			thresh <= i_cfg_thresh;
			sweep <= i_cfg_sweep;
		end
	end

	always_ff @(posedge I_CORE_CLK or negedge I_RST_B) begin
		if (!I_RST_B) begin
			strobe_q <= 1'b1;
			div4 <= 2'h0;
		end else begin
			strobe_q <= i_conversion_strobe_b;
			if (i_sclk_fall) begin
				div4 <= div4 + 2'h1;
			end
		end
	end

	// Extended-mode tracking: exit after strobe high then two frame starts
	always_ff @(posedge I_CORE_CLK or negedge I_RST_B) begin
		if (!I_RST_B) begin
			o_ext_mode <= 1'b0;
			ext_frames <= 2'h0;
		end else if (strobe_fall) begin
			o_ext_mode <= 1'b1;
			ext_frames <= 2'h0;
		end else if (o_ext_mode && i_conversion_strobe_b && i_frame_start) begin
			if (ext_frames == 2'h1) begin
				o_ext_mode <= 1'b0;
				ext_frames <= 2'h0;
			end else begin
				ext_frames <= ext_frames + 2'h1;
			end
		end
	end

	// Channel selection; select commands are ignored while the FIFO holds results, in the full state, or in sweep modes
	always_ff @(posedge I_CORE_CLK or negedge I_RST_B) begin
		if (!I_RST_B) begin
			o_chan <= '0;
			sweep_pos <= 3'h0;
			armed <= 1'b0;
		end else begin
			if (i_select_command && o_fifo_level == 3'h0 && state != ascs_pkg::ST_FULL &&
				(mode == ascs_pkg::MODE_ONE_SHOT || mode == ascs_pkg::MODE_REPEAT)) begin
				o_chan <= i_select_chan;
			end else if (state == ascs_pkg::ST_CONVERT && conv_tick && conv_cnt == 5'(ascs_pkg::CONV_CLOCKS - 1) &&
				mode[1]) begin
				// Sweep walks sequence then wraps, remaining channels skipped at threshold
				sweep_pos <= last_sample ? 3'h0 : sweep_pos + 3'h1;
				o_chan <= CHAN_BITS'(last_sample ? 3'h0 : (sweep[0] ? {sweep_pos[1:0] + 2'h1, 1'b0} :
					sweep_pos + 3'h1));
			end
			if (i_config_write_command) begin
				// Every sweep sequence opens on channel 0
				sweep_pos <= 3'h0;
				o_chan <= '0;
			end
			// Arm frame after read or config in strobe-triggered sweep
			if (state == ascs_pkg::ST_FULL || i_config_write_command) begin
				armed <= 1'b0;
			end else if (i_frame_start) begin
				armed <= 1'b1;
			end
		end
	end

	// Main sequence
	always_ff @(posedge I_CORE_CLK or negedge I_RST_B) begin
		if (!I_RST_B) begin
			state <= ascs_pkg::ST_IDLE;
			sclk_cnt <= 6'h0;
			conv_cnt <= 5'h0;
			delay_cnt <= 4'h0;
			o_eoc_b <= 1'b1;
			o_int_b <= 1'b1;
			o_fifo_wr <= 1'b0;
			o_fifo_level <= 3'h0;
			o_result_ready <= 1'b0;
			o_sampling <= 1'b0;
		end else begin
			o_fifo_wr <= 1'b0;
			if (i_fifo_read_command || i_config_write_command) begin
				o_int_b <= 1'b1;
			end
			case (state)
				ascs_pkg::ST_IDLE: begin
					if (strobe_fall && (mode == ascs_pkg::MODE_ONE_SHOT || armed || mode == ascs_pkg::MODE_REPEAT)) begin
						o_sampling <= 1'b1;
						state <= ascs_pkg::ST_EXT_SAMPLE;
					end else if (trigger_frame) begin
						sclk_cnt <= 6'h0;
						state <= ascs_pkg::ST_COUNT;
					end
				end
				ascs_pkg::ST_COUNT: begin
					if (i_sclk_fall) begin
						sclk_cnt <= sclk_cnt + 6'h1;
						if (sclk_cnt == 6'(ascs_pkg::SAMPLE_START_EDGE - 1)) begin
							o_sampling <= 1'b1;
							state <= ascs_pkg::ST_SAMPLE;
						end
					end
				end
				ascs_pkg::ST_SAMPLE: begin
					if (i_sclk_fall) begin
						sclk_cnt <= sclk_cnt + 6'h1;
						// Edge 16 short or edge 48 long ends sampling
						if (sclk_cnt == 6'(ascs_pkg::SAMPLE_START_EDGE - 1 + (long_sample ?
							ascs_pkg::LONG_SAMPLE_SCLKS : ascs_pkg::SHORT_SAMPLE_SCLKS))) begin
							o_sampling <= 1'b0;
							o_eoc_b <= 1'b0;
							conv_cnt <= 5'h0;
							state <= ascs_pkg::ST_CONVERT;
						end
					end
				end
				ascs_pkg::ST_EXT_SAMPLE: begin
					if (strobe_rise) begin
						o_sampling <= 1'b0;
						delay_cnt <= 4'h0;
						state <= ascs_pkg::ST_DELAY;
					end
				end
				ascs_pkg::ST_DELAY: begin
					delay_cnt <= delay_cnt + 4'h1;
					if (delay_cnt == 4'(ascs_pkg::CONV_DELAY_CYC - 1)) begin
						o_eoc_b <= 1'b0;
						conv_cnt <= 5'h0;
						state <= ascs_pkg::ST_CONVERT;
					end
				end
				ascs_pkg::ST_CONVERT: begin
					if (trigger_frame || strobe_fall) begin
						// Early trigger cuts the conversion short
						o_eoc_b <= 1'b1;
						state <= ascs_pkg::ST_IDLE;
					end else if (conv_tick) begin
						conv_cnt <= conv_cnt + 5'h1;
						if (conv_cnt == 5'(ascs_pkg::CONV_CLOCKS - 1)) begin
							o_eoc_b <= 1'b1;
							if (mode == ascs_pkg::MODE_ONE_SHOT) begin
								o_result_ready <= 1'b1;
								o_int_b <= 1'b0;
								state <= ascs_pkg::ST_IDLE;
							end else begin
								o_fifo_wr <= 1'b1;
								o_fifo_level <= last_sample ? 3'h0 : o_fifo_level + 3'h1;
								if (last_sample) begin
									o_int_b <= 1'b0;
									// Sweep waits for read, repeat modes restart at once
									state <= (mode == ascs_pkg::MODE_SWEEP) ? ascs_pkg::ST_FULL :
										ascs_pkg::ST_IDLE;
								end else begin
									state <= ascs_pkg::ST_IDLE;
								end
							end
						end
					end
				end
				ascs_pkg::ST_FULL: begin
					if (i_fifo_read_command || i_config_write_command) begin
						state <= ascs_pkg::ST_IDLE;
					end
				end
				default: state <= ascs_pkg::ST_IDLE;
			endcase
			if (trigger_frame && mode == ascs_pkg::MODE_ONE_SHOT) begin
				o_result_ready <= 1'b0;
			end
			if (i_config_write_command) begin
				o_fifo_level <= 3'h0;
			end
		end
	end
endmodule : ascs_sequencer

// *** logic/ascs_pkg.sv ***
// Constants and types for the sample and conversion sequencer
// Operation
// - Short sampling lasts 12 bit clocks, starting after the fourth falling edge.
// - Long sampling is the same but lasts 44 bit clocks.
// - Extended sampling starts on strobe fall and lasts while the strobe is low.
// - Strobe rise ends sampling; conversion starts about 15 ns later.
// - Leave extended mode after strobe high plus two frame starts; first converts nothing. The code samples on neither; the next frame converts.
// - Conversion starts after falling edge 16 (short) or 48 (long).
// - A conversion takes 18 conversion clocks plus 15 ns.
// - Conversion clock is the internal oscillator or bit clock divided by four.
// - End-of-conversion is low during conversion; interrupt falls at its end.
// - Mode 00 does one sample and conversion, no FIFO, result out next frame.
// - Mode 01 converts one channel into the FIFO until threshold, then interrupts.
// - Threshold code 00,01,10,11 means stop after level 7,5,3,1.
// - Mode 01 overwrites unread FIFO results on the next operation.
// - Channel commands during frame triggers in modes 01 and 10 are dummies.
// - Mode 01 with strobe triggers restarts at once after the FIFO fills.
// - Mode 10 converts the sweep sequence into the FIFO, stops at threshold.
// - Mode 10 stays idle after filling until FIFO read or config write.
// - Mode 11 is like mode 10 but restarts at once and overwrites the FIFO.
package ascs_pkg;
	localparam int SHORT_SAMPLE_SCLKS = 12;
	localparam int LONG_SAMPLE_SCLKS = 44;
	localparam int SAMPLE_START_EDGE = 4;
	localparam int CONV_CLOCKS = 18;
	localparam int SCLK_PER_CONV_CLK = 4;
	localparam int CLK_PERIOD_NS = 50;
	localparam int CONV_DELAY_NS = 15;
	// Least time rounds up to whole cycles
	localparam int CONV_DELAY_CYC = (CONV_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [1:0] MODE_ONE_SHOT = 2'h0;
	localparam logic [1:0] MODE_REPEAT = 2'h1;
	localparam logic [1:0] MODE_SWEEP = 2'h2;
	localparam logic [1:0] MODE_REPEAT_SWEEP = 2'h3;
	localparam logic [1:0] RST_MODE = 2'h0;
	localparam logic [1:0] RST_THRESH = 2'h0;
	localparam logic [1:0] RST_SWEEP = 2'h0;
	localparam logic [2:0] LEVEL_T00 = 3'h7;
	localparam logic [2:0] LEVEL_T01 = 3'h5;
	localparam logic [2:0] LEVEL_T10 = 3'h3;
	localparam logic [2:0] LEVEL_T11 = 3'h1;
	typedef enum logic [2:0] {
		ST_IDLE,
		ST_COUNT,
		ST_SAMPLE,
		ST_EXT_SAMPLE,
		ST_DELAY,
		ST_CONVERT,
		ST_FULL
	} ascs_state_t;
endpackage : ascs_pkg

// *** bench/ascs_host_model.sv ***
// Host side model: bit clock falls and conversion oscillator ticks
module ascs_host_model (
	input wire logic i_clk,
	input wire logic i_rst_b,
	input wire logic i_run,
	output logic o_sclk_fall,
	output logic o_osc_tick
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [1:0] div;
	// Bit clock stands still outside frames
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			div <= 2'h0;
			o_sclk_fall <= 1'b0;
			o_osc_tick <= 1'b0;
		end else begin
			div <= div + 2'h1;
			o_sclk_fall <= i_run && div[0];
			o_osc_tick <= div == 2'h3;
		end
	end
endmodule : ascs_host_model

// *** bench/ascs_sequencer_properties.sv ***
// Port checks for the sequencer
module ascs_sequencer_properties (
	input wire logic I_CORE_CLK,
	input wire logic I_RST_B,
	input wire logic i_frame_start,
	input wire logic i_conversion_strobe_b,
	input wire logic i_config_write_command,
	input wire logic i_fifo_read_command,
	input wire logic o_sampling,
	input wire logic o_eoc_b,
	input wire logic o_int_b,
	input wire logic o_fifo_wr,
	input wire logic o_ext_mode
);
	default clocking @(posedge I_CORE_CLK); endclocking
	default disable iff (!I_RST_B);
	sequence s_quiet;
		!o_sampling [*4];
	endsequence
	a_conv_after_sample: assert property ($fell(o_sampling) && !o_ext_mode |-> !o_eoc_b)
		else $error("conversion did not follow sampling");
	a_strobe_conv: assert property (o_ext_mode && o_sampling && $rose(i_conversion_strobe_b) |-> ##[1:2] !o_eoc_b)
		else $error("strobe rise did not start conversion");
	a_ext_start: assert property ($fell(i_conversion_strobe_b) && o_eoc_b |-> ##[1:2] (o_sampling && o_ext_mode))
		else $error("strobe fall did not start sampling");
	a_no_overlap: assert property (!o_eoc_b |-> !o_sampling)
		else $error("sampling during conversion");
	a_wr_pulse: assert property (o_fifo_wr |=> !o_fifo_wr)
		else $error("store pulse too long");
	a_wr_at_end: assert property (o_fifo_wr |-> $rose(o_eoc_b))
		else $error("store not at conversion end");
	a_read_clears: assert property (i_fifo_read_command && !o_fifo_wr |=> o_int_b)
		else $error("read left interrupt low");
	a_cfg_clears: assert property (i_config_write_command && !o_fifo_wr |=> o_int_b)
		else $error("config write left interrupt low");
	a_ext_frame_quiet: assert property (o_ext_mode && i_frame_start |=> s_quiet)
		else $error("frame sampled in extended mode");
endmodule : ascs_sequencer_properties
bind ascs_sequencer ascs_sequencer_properties ascs_props_i (.I_CORE_CLK, .I_RST_B, .i_frame_start,
	.i_conversion_strobe_b, .i_config_write_command, .i_fifo_read_command, .o_sampling, .o_eoc_b, .o_int_b,
	.o_fifo_wr, .o_ext_mode);

// *** bench/tb_top.sv ***
// Self-checking testbench for the sequencer
module tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk = 0, rst_b = 0, run = 0, fs = 0, stb_b = 1, cfgw = 0, ext = 0, lng = 0, sel = 0, rd = 0;
	logic [1:0] mode = 0, th = 0, sw = 0;
	logic [2:0] chan = 0, och, lvl;
	logic [2:0] cur = 0;
	logic sclk, osc, smp, eoc_b, int_b, wr, rdy, xm;
	logic [15:0] n_smp = 0, n_wr = 0, n_cnv = 0, log = 0;
	int failures = 0;
	int checks_done = 0;
	always #25 clk = ~clk;
	ascs_host_model ascs_host_model_i (.i_clk(clk), .i_rst_b(rst_b), .i_run(run), .o_sclk_fall(sclk),
		.o_osc_tick(osc));
	ascs_sequencer ascs_sequencer_i (.I_CORE_CLK(clk), .I_RST_B(rst_b), .i_sclk_fall(sclk), .i_osc_tick(osc),
		.i_frame_start(fs), .i_conversion_strobe_b(stb_b), .i_config_write_command(cfgw), .i_cfg_mode(mode),
		.i_cfg_ext_clk(ext), .i_cfg_long_sample(lng), .i_cfg_thresh(th), .i_cfg_sweep(sw), .i_select_command(sel),
		.i_select_chan(chan), .i_fifo_read_command(rd), .o_sampling(smp), .o_eoc_b(eoc_b), .o_int_b(int_b),
		.o_chan(och), .o_fifo_wr(wr), .o_fifo_level(lvl), .o_result_ready(rdy), .o_ext_mode(xm));
	always @(posedge clk) begin
		n_smp <= fs ? 16'h0000 : n_smp + 16'(smp && sclk);
		n_cnv <= fs ? 16'h0000 : n_cnv + 16'(!eoc_b && sclk);
		n_wr <= cfgw ? 16'h0000 : n_wr + 16'(wr);
		// Channel advances with the store pulse, so log the one held while converting
		if (!eoc_b)
			cur <= och;
		if (wr)
			log <= {log[11:0], 1'b0, cur};
	end
	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		checks_done++;
		if (seen !== exp) begin
			failures++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	task automatic step(input int n);
		repeat (n) @(posedge clk);
		#5;
	endtask : step
	task automatic pulse(ref logic s);
		s = 1;
		step(1);
		s = 0;
	endtask : pulse
	task automatic wait_eoc(input logic v);
		for (int k = 0; k < 300 && eoc_b !== v; k++)
			step(1);
	endtask : wait_eoc
	task automatic configure(input logic [1:0] m, input logic [1:0] t, input logic [1:0] s, input logic e, input logic l);
		mode = m;
		th = t;
		sw = s;
		ext = e;
		lng = l;
		pulse(cfgw);
	endtask : configure
	// Next trigger only once the conversion has ended
	// Frames only, chip select never toggles mid conversion
	task automatic frame();
		pulse(fs);
		run = 1;
		wait_eoc(0);
		wait_eoc(1);
		run = 0;
		step(2);
	endtask : frame
	task automatic give_verdict();
		if (failures == 0 && checks_done > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : give_verdict
	initial begin
		step(20000);
		failures++;
		give_verdict();
	end
	initial begin
		step(3);
		rst_b = 1;
		check("eoc_b", 16'(eoc_b), 16'h0001);
		for (int l = 0; l < 2; l++) begin
			configure(ascs_pkg::MODE_ONE_SHOT, 0, 0, 0, l[0]);
			frame();
			check("samples", n_smp, l ? 16'h002c : 16'h000c);
			check("int_b", 16'(int_b), 16'h0000);
			check("ready", 16'(rdy), 16'h0001);
		end
		configure(ascs_pkg::MODE_ONE_SHOT, 0, 0, 1, 0);
		frame();
		check("ext clock", 16'(n_cnv >= 69 && n_cnv <= 73), 16'h0001);
		// Config, select, then frames with dummy selects
		for (int t = 0; t < 4; t++) begin
			configure(ascs_pkg::MODE_REPEAT, t[1:0], 0, 0, 0);
			chan = 5;
			pulse(sel);
			chan = 2;
			frame();
			repeat (6 - 2 * t) begin
				pulse(sel);
				frame();
			end
			check("stored", n_wr, 16'(7 - 2 * t));
			check("int_b", 16'(int_b), 16'h0000);
			check("level", 16'(lvl), 16'h0000);
			check("chan", 16'(och), 16'h0005);
		end
		configure(ascs_pkg::MODE_SWEEP, 2'h2, 2'h1, 0, 0);
		repeat (4)
			frame();
		check("sweep", n_wr, 16'h0003);
		check("order", log[11:0], 16'h0024);
		pulse(rd);
		frame();
		check("resume", n_wr, 16'h0004);
		configure(ascs_pkg::MODE_REPEAT_SWEEP, 2'h3, 2'h1, 0, 0);
		frame();
		frame();
		check("repeat sweep", n_wr, 16'h0002);
		configure(ascs_pkg::MODE_ONE_SHOT, 0, 0, 0, 0);
		stb_b = 0;
		step(3);
		check("ext mode", 16'({xm, smp}), 16'h0003);
		stb_b = 1;
		step(3);
		check("eoc_b", 16'(eoc_b), 16'h0000);
		wait_eoc(1);
		frame();
		check("first frame", n_smp, 16'h0000);
		pulse(fs);
		check("ext mode", 16'(xm), 16'h0000);
		give_verdict();
	end
endmodule : tb_top
